// file: hw/oag_top.sv
`timescale 1ns/1ps
`default_nettype none
module oag_top (
  input  wire logic                 core_clk,
  input  wire logic                 resetn,
  input  wire logic                 req_valid,
  input  wire oag_pkg::oag_mode_t   req_mode,
  input  wire oag_pkg::oag_ptr_t    req_ptr,
  input  wire logic [4:0]           req_dst,
  input  wire logic [15:0]          req_direct,
  input  wire logic [5:0]           req_disp,
  input  wire logic                 wait_states_en,
  input  wire logic                 ptr_wr_en,
  input  wire logic [1:0]           ptr_wr_sel,
  input  wire logic [15:0]          ptr_wr_data,
  output logic                      req_ready,
  output logic                      addr_valid,
  output logic [15:0]               data_addr,
  output logic [14:0]               prog_word_addr,
  output logic                      prog_high_byte,
  output logic                      prog_valid,
  output logic                      addr_is_reg,
  output logic                      addr_is_io,
  output logic                      addr_is_sram,
  output logic                      addr_is_ext,
  output logic [2:0]                extra_cycles,
  output logic [15:0]               ptr_x,
  output logic [15:0]               ptr_y,
  output logic [15:0]               ptr_z
);
  import oag_pkg::*;

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    oag_state_t  st;
    logic [2:0]  wait_cnt;
    logic        addr_valid;
    logic [15:0] data_addr;
    logic        prog_valid;
    logic [14:0] prog_word;
    logic        prog_hi;
    logic [2:0]  extra;
    logic        is_reg;
    logic        is_io;
    logic        is_sram;
    logic        is_ext;
    logic [15:0] x_copy;
    logic [15:0] y_copy;
  } oag_state_s_t;

  oag_state_s_t s_q;
  oag_state_s_t s_d;

  logic [15:0] base;
  logic [15:0] zval;
  logic [15:0] pre_dec;
  logic [15:0] post_inc;
  logic [15:0] disp_addr;
  logic [15:0] eff;
  logic        upd_en;
  logic [15:0] upd_data;
  logic [1:0]  upd_sel;
  logic        accept;
  logic [2:0]  wait_need;
  logic        rgn_reg;
  logic        rgn_io;
  logic        rgn_sram;
  logic        rgn_ext;

  assign req_ready = (s_q.st == OAG_ST_IDLE);
  assign accept    = req_valid && req_ready;

  oag_ptr_file u_ptr (
    .core_clk (core_clk),
    .resetn   (resetn),
    .wr_en    (upd_en),
    .wr_sel   (upd_sel),
    .wr_data  (upd_data),
    .rd_sel   (req_ptr),
    .rd_data  (base),
    .z_data   (zval)
  );

  // ------------------------------------------------------------------
  // Address arithmetic
  // ------------------------------------------------------------------
  assign pre_dec   = base - 16'h0001;
  assign post_inc  = base + 16'h0001;
  assign disp_addr = base + {10'h000, req_disp};

  always_comb begin
    eff = base;
    case (req_mode)
      OAG_MODE_REG:     eff = {11'h000, req_dst};
      OAG_MODE_DIRECT:  eff = req_direct;
      OAG_MODE_IND:     eff = base;
      OAG_MODE_DISP:    eff = disp_addr;
      OAG_MODE_PREDEC:  eff = pre_dec;
      OAG_MODE_POSTINC: eff = base;
      default:          eff = base;
    endcase
  end

  // ------------------------------------------------------------------
  // Data space regions of the operand address
  // ------------------------------------------------------------------
  // Flags are registered with the address so they line up with addr_valid
  always_comb begin
    rgn_reg  = 1'b0;
    rgn_io   = 1'b0;
    rgn_sram = 1'b0;
    rgn_ext  = 1'b0;
    if (eff < IO_BASE) begin
      rgn_reg = 1'b1;
    end else if (eff < SRAM_BASE) begin
      rgn_io = 1'b1;
    end else if (eff <= SRAM_LAST) begin
      rgn_sram = 1'b1;
    end else begin
      rgn_ext = 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // Wait-state demand of the request on the bus
  // ------------------------------------------------------------------
  // Register mode never reaches the external bus, whatever eff holds
  always_comb begin
    wait_need = 3'h0;
    if (wait_states_en) begin
      if (req_mode == OAG_MODE_FLOW) begin
        wait_need = FLOW_WAIT_CYC;
      end else if (req_mode != OAG_MODE_CONST && req_mode != OAG_MODE_REG && rgn_ext) begin
        wait_need = XMEM_WAIT_CYC;
      end
    end
  end

  // Core writes lose to auto-modify in the same cycle: the mode's write replaces a core write to any pair
  always_comb begin
    upd_en   = ptr_wr_en;
    upd_sel  = ptr_wr_sel;
    upd_data = ptr_wr_data;
    if (accept && req_mode == OAG_MODE_PREDEC && req_ptr != 2'h3) begin
      upd_en   = 1'b1;
      upd_sel  = req_ptr;
      upd_data = pre_dec;
    end else if (accept && req_mode == OAG_MODE_POSTINC && req_ptr != 2'h3) begin
      upd_en   = 1'b1;
      upd_sel  = req_ptr;
      upd_data = post_inc;
    end
  end

  // ------------------------------------------------------------------
  // Issue and wait-state sequencing
  // ------------------------------------------------------------------
  always_comb begin
    s_d            = s_q;
    s_d.addr_valid = 1'b0;
    s_d.prog_valid = 1'b0;
    // Copies follow every write the pointer file takes, so they never lag it
    if (upd_en && upd_sel == OAG_PTR_X) begin
      s_d.x_copy = upd_data;
    end
    if (upd_en && upd_sel == OAG_PTR_Y) begin
      s_d.y_copy = upd_data;
    end
    case (s_q.st)
      OAG_ST_IDLE: begin
        if (accept) begin
          s_d.extra = wait_need;
          if (req_mode == OAG_MODE_CONST) begin
            s_d.prog_word  = zval[15:1];
            s_d.prog_hi    = zval[0];
            s_d.prog_valid = 1'b1;
          end else if (req_mode != OAG_MODE_FLOW) begin
            s_d.data_addr  = eff;
            s_d.addr_valid = 1'b1;
            s_d.is_reg     = rgn_reg;
            s_d.is_io      = rgn_io;
            s_d.is_sram    = rgn_sram;
            s_d.is_ext     = rgn_ext;
          end
          if (wait_need != 3'h0) begin
            s_d.st       = OAG_ST_WAIT;
            s_d.wait_cnt = wait_need;
          end
        end
      end
      OAG_ST_WAIT: begin
        // Holds off the next request for the inserted cycles
        s_d.wait_cnt = s_q.wait_cnt - 3'h1;
        if (s_q.wait_cnt == 3'h1) begin
          s_d.st = OAG_ST_IDLE;
        end
      end
      default: s_d.st = OAG_ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign addr_valid     = s_q.addr_valid;
  assign data_addr      = s_q.data_addr;
  assign prog_valid     = s_q.prog_valid;
  assign prog_word_addr = s_q.prog_word;
  assign prog_high_byte = s_q.prog_hi;
  assign extra_cycles   = s_q.extra;
  assign addr_is_reg    = s_q.is_reg;
  assign addr_is_io     = s_q.is_io;
  assign addr_is_sram   = s_q.is_sram;
  assign addr_is_ext    = s_q.is_ext;
  assign ptr_x          = s_q.x_copy;
  assign ptr_y          = s_q.y_copy;
  assign ptr_z          = zval;
endmodule : oag_top
`default_nettype wire

// file: hw/oag_pkg.sv
// Summary of operation
// - With wait states on, add two cycles per external data byte.
// - With wait states on, interrupt entry, call and return take four extra cycles.
// - Registers 26 to 31 form the three 16-bit pointer pairs.
// - Direct mode takes the full 16-bit address from the instruction.
// - Displacement mode: second or third pair plus displacement, 63 locations; the code also accepts the first pair as base.
// - Pre-decrement: decrement pointer first, use decremented value.
// - Post-increment: use old pointer value, then increment pointer.
// - Constant load: upper 15 bits of third pair are word address, LSB picks byte.
// - Single register mode: operand is register named by destination field.
// - Direct, indirect, displacement, pre-decrement and post-increment modes reach registers, I/O, internal and external memory.
package oag_pkg;

  // ------------------------------------------------------------------
  // Address map and constants
  // ------------------------------------------------------------------
  localparam int unsigned ADDR_W        = 16;
  localparam int unsigned REG_NUM_W     = 5;
  localparam int unsigned DISP_W        = 6;
  localparam logic [4:0]  PTR_BASE_REG  = 5'h1a;
  localparam logic [15:0] IO_BASE       = 16'h0020;
  localparam logic [15:0] SRAM_BASE     = 16'h0060;
  localparam logic [15:0] SRAM_LAST     = 16'h025f;
  localparam logic [2:0]  XMEM_WAIT_CYC = 3'h2;
  localparam logic [2:0]  FLOW_WAIT_CYC = 3'h4;
  localparam logic [15:0] PTR_RESET     = 16'h0000;

  typedef enum logic [2:0] {
    OAG_MODE_REG    = 3'b000,
    OAG_MODE_DIRECT = 3'b001,
    OAG_MODE_IND    = 3'b010,
    OAG_MODE_DISP   = 3'b011,
    OAG_MODE_PREDEC = 3'b100,
    OAG_MODE_POSTINC= 3'b101,
    OAG_MODE_CONST  = 3'b110,
    OAG_MODE_FLOW   = 3'b111
  } oag_mode_t;

  typedef enum logic [1:0] {
    OAG_PTR_X = 2'b00,
    OAG_PTR_Y = 2'b01,
    OAG_PTR_Z = 2'b10
  } oag_ptr_t;

  typedef enum logic [0:0] {
    OAG_ST_IDLE = 1'b0,
    OAG_ST_WAIT = 1'b1
  } oag_state_t;

endpackage : oag_pkg

// file: hw/oag_ptr_file.sv
`timescale 1ns/1ps
`default_nettype none
module oag_ptr_file (
  input  wire logic              core_clk,
  input  wire logic              resetn,
  input  wire logic              wr_en,
  input  wire logic [1:0]        wr_sel,
  input  wire logic [15:0]       wr_data,
  input  wire logic [1:0]        rd_sel,
  output logic      [15:0]       rd_data,
  output logic      [15:0]       z_data
);
  import oag_pkg::*;

  typedef struct packed {
    logic [2:0][15:0] ptr;
  } oag_pf_state_t;

  oag_pf_state_t s_q;
  oag_pf_state_t s_d;

  // ------------------------------------------------------------------
  // Three pairs, registers 26..31, low byte at even number
  // ------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    if (wr_en && wr_sel != 2'h3) begin
      s_d.ptr[wr_sel] = wr_data;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rd_data = (rd_sel == 2'h3) ? PTR_RESET : s_q.ptr[rd_sel];
  assign z_data  = s_q.ptr[OAG_PTR_Z];
endmodule : oag_ptr_file
`default_nettype wire

// file: tb/oag_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module oag_chk (
  input wire logic               core_clk,
  input wire logic               resetn,
  input wire logic               req_valid,
  input wire oag_pkg::oag_mode_t req_mode,
  input wire oag_pkg::oag_ptr_t  req_ptr,
  input wire logic [15:0]        req_direct,
  input wire logic [5:0]         req_disp,
  input wire logic               wait_states_en,
  input wire logic               req_ready,
  input wire logic               addr_valid,
  input wire logic [15:0]        data_addr,
  input wire logic [14:0]        prog_word_addr,
  input wire logic               prog_high_byte,
  input wire logic               prog_valid,
  input wire logic               addr_is_sram,
  input wire logic [2:0]         extra_cycles,
  input wire logic [15:0]        ptr_x,
  input wire logic [15:0]        ptr_y,
  input wire logic [15:0]        ptr_z
);
  import oag_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  logic acc;
  assign acc = req_valid && req_ready;

  AST_PREDEC: assert property (acc && req_mode == OAG_MODE_PREDEC && req_ptr == OAG_PTR_X |=>
    addr_valid && data_addr == $past(ptr_x) - 16'h1 && ptr_x == data_addr) else $error("predec wrong");
  AST_POSTINC: assert property (acc && req_mode == OAG_MODE_POSTINC && req_ptr == OAG_PTR_X |=>
    addr_valid && data_addr == $past(ptr_x) && ptr_x == data_addr + 16'h1) else $error("postinc wrong");
  AST_DIRECT: assert property (acc && req_mode == OAG_MODE_DIRECT |=>
    addr_valid && data_addr == $past(req_direct)) else $error("direct wrong");
  AST_DISP: assert property (acc && req_mode == OAG_MODE_DISP && req_ptr == OAG_PTR_Y |=>
    data_addr == $past(ptr_y) + {10'h0, $past(req_disp)} && $stable(ptr_y)) else $error("disp wrong");
  AST_CONST: assert property (acc && req_mode == OAG_MODE_CONST |=>
    prog_valid && {prog_word_addr, prog_high_byte} == $past(ptr_z)) else $error("const load wrong");
  AST_XWAIT: assert property (addr_valid && data_addr > SRAM_LAST && $past(wait_states_en)
    && $past(req_mode) != OAG_MODE_REG |-> extra_cycles == 3'h2 && !req_ready ##1 !req_ready ##1 req_ready)
    else $error("external wait wrong");
  AST_FLOW: assert property (acc && req_mode == OAG_MODE_FLOW && wait_states_en |=>
    extra_cycles == 3'h4 && !req_ready [*4] ##1 req_ready) else $error("flow wait wrong");
  AST_DECODE: assert property (addr_valid |->
    addr_is_sram == (data_addr >= SRAM_BASE && data_addr <= SRAM_LAST)) else $error("decode wrong");
endmodule : oag_chk

bind oag_top oag_chk u_chk (.core_clk(core_clk), .resetn(resetn), .req_valid(req_valid),
  .req_mode(req_mode), .req_ptr(req_ptr), .req_direct(req_direct), .req_disp(req_disp),
  .wait_states_en(wait_states_en), .req_ready(req_ready), .addr_valid(addr_valid),
  .data_addr(data_addr), .prog_word_addr(prog_word_addr), .prog_high_byte(prog_high_byte),
  .prog_valid(prog_valid), .addr_is_sram(addr_is_sram), .extra_cycles(extra_cycles),
  .ptr_x(ptr_x), .ptr_y(ptr_y), .ptr_z(ptr_z));
`default_nettype wire

// file: tb/oag_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module oag_top_test;
  import oag_pkg::*;
  logic        core_clk = 1'b0, resetn = 1'b0, req_valid = 1'b0, wait_states_en = 1'b0, ptr_wr_en = 1'b0;
  oag_mode_t   req_mode = OAG_MODE_REG;
  oag_ptr_t    req_ptr = OAG_PTR_X;
  logic [4:0]  req_dst = 5'h00;
  logic [5:0]  req_disp = 6'h00;
  logic [1:0]  ptr_wr_sel = 2'h0;
  logic [15:0] req_direct = 16'h0000, ptr_wr_data = 16'h0000;
  logic        req_ready, addr_valid, prog_high_byte, prog_valid;
  logic        addr_is_reg, addr_is_io, addr_is_sram, addr_is_ext;
  logic [2:0]  extra_cycles;
  logic [14:0] prog_word_addr;
  logic [15:0] data_addr, ptr_x, ptr_y, ptr_z;
  int          err_total = 0, tests_run = 0;

  oag_top uut (.core_clk(core_clk), .resetn(resetn), .req_valid(req_valid), .req_mode(req_mode),
    .req_ptr(req_ptr), .req_dst(req_dst), .req_direct(req_direct), .req_disp(req_disp),
    .wait_states_en(wait_states_en), .ptr_wr_en(ptr_wr_en), .ptr_wr_sel(ptr_wr_sel),
    .ptr_wr_data(ptr_wr_data), .req_ready(req_ready), .addr_valid(addr_valid), .data_addr(data_addr),
    .prog_word_addr(prog_word_addr), .prog_high_byte(prog_high_byte), .prog_valid(prog_valid),
    .addr_is_reg(addr_is_reg), .addr_is_io(addr_is_io), .addr_is_sram(addr_is_sram),
    .addr_is_ext(addr_is_ext), .extra_cycles(extra_cycles), .ptr_x(ptr_x), .ptr_y(ptr_y), .ptr_z(ptr_z));

  always #12.5 core_clk = ~core_clk;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [1:0] s, input logic [15:0] d);
    @(negedge core_clk);
    ptr_wr_en = 1'b1;
    ptr_wr_sel = s;
    ptr_wr_data = d;
    @(negedge core_clk);
    ptr_wr_en = 1'b0;
  endtask : wr

  // Returns at the falling edge after the accept, where the answer pulse stands
  task automatic rq(input oag_mode_t m, input oag_ptr_t p, input logic [15:0] a);
    int n;
    n = 0;
    @(negedge core_clk);
    while (req_ready !== 1'b1 && n < 20) begin
      n++;
      @(negedge core_clk);
    end
    if (n == 20) chk({15'h0, req_ready}, 16'h0001);
    req_valid = 1'b1;
    req_mode = m;
    req_ptr = p;
    req_direct = a;
    req_dst = a[4:0];
    req_disp = a[5:0];
    @(negedge core_clk);
    req_valid = 1'b0;
  endtask : rq

  task automatic rdy(input int e);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 10) begin
      n++;
      @(negedge core_clk);
    end
    chk(n[15:0], e[15:0]);
  endtask : rdy

  task automatic t_ptrs();
    wr(2'h0, 16'h0100);
    wr(2'h1, 16'h0060);
    wr(2'h2, 16'h1235);
    @(negedge core_clk);
    chk(ptr_x, 16'h0100);
    chk(ptr_y, 16'h0060);
    chk(ptr_z, 16'h1235);
  endtask : t_ptrs

  task automatic t_modes();
    rq(OAG_MODE_REG, OAG_PTR_X, 16'h001f);
    chk(data_addr, 16'h001f);
    chk({15'h0, addr_is_reg}, 16'h0001);
    chk({15'h0, addr_valid}, 16'h0001);
    rq(OAG_MODE_DIRECT, OAG_PTR_X, 16'h0040);
    chk({15'h0, addr_is_io}, 16'h0001);
    rq(OAG_MODE_DIRECT, OAG_PTR_X, 16'hffff);
    chk(data_addr, 16'hffff);
    chk({15'h0, addr_is_ext}, 16'h0001);
    rq(OAG_MODE_DISP, OAG_PTR_Y, 16'h003f);
    chk(data_addr, 16'h009f);
    chk(ptr_y, 16'h0060);
    chk({15'h0, addr_is_sram}, 16'h0001);
    rq(OAG_MODE_PREDEC, OAG_PTR_X, 16'h0000);
    chk(data_addr, 16'h00ff);
    chk(ptr_x, 16'h00ff);
    rq(OAG_MODE_POSTINC, OAG_PTR_X, 16'h0000);
    chk(data_addr, 16'h00ff);
    chk(ptr_x, 16'h0100);
    rq(OAG_MODE_IND, OAG_PTR_X, 16'h0000);
    chk(data_addr, 16'h0100);
    chk({15'h0, addr_is_sram}, 16'h0001);
    rq(OAG_MODE_CONST, OAG_PTR_Z, 16'h0000);
    chk({prog_valid, prog_word_addr}, 16'h891a);
    chk({15'h0, prog_high_byte}, 16'h0001);
    wr(2'h2, 16'h1234);
    rq(OAG_MODE_CONST, OAG_PTR_Z, 16'h0000);
    chk({15'h0, prog_high_byte}, 16'h0000);
  endtask : t_modes

  task automatic t_wait();
    @(negedge core_clk);
    wait_states_en = 1'b1;
    rq(OAG_MODE_DIRECT, OAG_PTR_X, 16'h8000);
    chk({13'h0, extra_cycles}, 16'h0002);
    rdy(2);
    rq(OAG_MODE_DIRECT, OAG_PTR_X, 16'h0100);
    chk({13'h0, extra_cycles}, 16'h0000);
    rq(OAG_MODE_FLOW, OAG_PTR_X, 16'h0000);
    chk({13'h0, extra_cycles}, 16'h0004);
    rdy(4);
  endtask : t_wait

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict

  initial begin
    repeat (8) @(negedge core_clk);
    resetn = 1'b1;
    t_ptrs();
    t_modes();
    t_wait();
    print_verdict();
  end

  // Whole run is under 100 cycles; 4000 cycles means a hang
  initial begin
    #100000;
    err_total++;
    print_verdict();
  end
endmodule : oag_top_test
`default_nettype wire
